// >>> rtc_pkg.sv
// rtc_pkg: constants, field layouts and BCD helpers of the calendar clock.
// assumes a 40 MHz clk and byte-wide registers on a plain strobe port.
`default_nettype none
package rtc_pkg;
	localparam int ADDR_W = 4;
	// register indices
	localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
	localparam logic [ADDR_W-1:0] REG_ALARM_CTL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_ALARM_RPT = 4'h2;
	localparam logic [ADDR_W-1:0] REG_YEAR      = 4'h3;
	localparam logic [ADDR_W-1:0] REG_MONTH     = 4'h4;
	localparam logic [ADDR_W-1:0] REG_DAY       = 4'h5;
	localparam logic [ADDR_W-1:0] REG_WDAY      = 4'h6;
	localparam logic [ADDR_W-1:0] REG_HOURS     = 4'h7;
	localparam logic [ADDR_W-1:0] REG_MINUTES   = 4'h8;
	localparam logic [ADDR_W-1:0] REG_SECONDS   = 4'h9;
	localparam logic [ADDR_W-1:0] REG_AL_MONTH  = 4'hA;
	localparam logic [ADDR_W-1:0] REG_AL_DAY    = 4'hB;
	localparam logic [ADDR_W-1:0] REG_AL_WDAY   = 4'hC;
	localparam logic [ADDR_W-1:0] REG_AL_HOURS  = 4'hD;
	localparam logic [ADDR_W-1:0] REG_AL_MIN    = 4'hE;
	localparam logic [ADDR_W-1:0] REG_AL_SEC    = 4'hF;
	// field positions
	localparam int CTRL_RUN_BIT    = 7;
	localparam int CTRL_UNLOCK_BIT = 5;
	localparam int CTRL_SYNC_BIT   = 4;
	localparam int CTRL_HALF_BIT   = 0;
	localparam int AL_ARM_BIT      = 7;
	localparam int AL_CHIME_BIT    = 6;
	localparam int AL_IVL_LSB      = 2;
	// timing
	localparam longint CLK_PERIOD_NS      = 25;
	localparam longint HALF_SEC_NS        = 500000000;
	localparam int HALF_SEC_CYCLES_DEF    = int'(HALF_SEC_NS / CLK_PERIOD_NS);
	localparam int SYNC_WINDOW_CYCLES     = 32;
	// BCD limits
	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] MIN_MAX   = 8'h59;
	localparam logic [7:0] HOUR_MAX  = 8'h23;
	localparam logic [7:0] MON_MAX   = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] WDAY_MAX  = 8'h06;
	localparam logic [7:0] FIRST_ONE = 8'h01;
	localparam logic [7:0] BCD_ZERO  = 8'h00;
	localparam logic [7:0] RPT_MAX   = 8'hFF;
	// alarm interval codes
	localparam logic [3:0] IVL_HALF = 4'h0;
	localparam logic [3:0] IVL_SEC  = 4'h1;
	localparam logic [3:0] IVL_10S  = 4'h2;
	localparam logic [3:0] IVL_MIN  = 4'h3;
	localparam logic [3:0] IVL_10M  = 4'h4;
	localparam logic [3:0] IVL_HOUR = 4'h5;
	localparam logic [3:0] IVL_DAY  = 4'h6;
	localparam logic [3:0] IVL_WEEK = 4'h7;
	localparam logic [3:0] IVL_MON  = 4'h8;
	localparam logic [3:0] IVL_YEAR = 4'h9;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} time_s;

	typedef struct packed {
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} alarm_s;

	localparam time_s TIME_RST = '{year: 8'h00, month: 8'h01, day: 8'h01, wday: 8'h00,
		hour: 8'h00, min: 8'h00, sec: 8'h00};
	localparam alarm_s ALARM_RST = '{month: 8'h01, day: 8'h01, wday: 8'h00,
		hour: 8'h00, min: 8'h00, sec: 8'h00};

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {4'(v[7:4] + 4'h1), 4'h0};
		return {v[7:4], 4'(v[3:0] + 4'h1)};
	endfunction

	// years 00..99 of 2000..2099: every fourth year, 2000 included
	function automatic logic is_leap(input logic [7:0] y);
		if (y[4])
			return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02: return is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> calendar_step.sv
// calendar_step: the calendar one second later, all fields in BCD.
// assumes the input holds legal BCD values; combinational only.
`default_nettype none
module calendar_step (
	input  wire rtc_pkg::time_s cur,
	output rtc_pkg::time_s      nxt
);
	import rtc_pkg::*;
	logic c_min;
	logic c_hr;
	logic c_day;
	logic c_mon;

	always_comb begin
		nxt   = cur;
		c_min = (cur.sec == SEC_MAX);
		c_hr  = c_min && (cur.min == MIN_MAX);
		c_day = c_hr && (cur.hour == HOUR_MAX);
		c_mon = c_day && (cur.day == last_day(cur.month, cur.year));
		nxt.sec = c_min ? BCD_ZERO : bcd_inc(cur.sec);
		if (c_min)
			nxt.min = c_hr ? BCD_ZERO : bcd_inc(cur.min);
		if (c_hr)
			nxt.hour = c_day ? BCD_ZERO : bcd_inc(cur.hour);
		if (c_day) begin
			nxt.day  = c_mon ? FIRST_ONE : bcd_inc(cur.day);
			// wday just runs on; software sets it to match the date
			nxt.wday = (cur.wday == WDAY_MAX) ? BCD_ZERO : 8'(cur.wday + 8'h01);
		end
		if (c_mon)
			nxt.month = (cur.month == MON_MAX) ? FIRST_ONE : bcd_inc(cur.month);
		if (c_mon && cur.month == MON_MAX)
			nxt.year = (cur.year == YEAR_MAX) ? BCD_ZERO : bcd_inc(cur.year);
	end
endmodule // calendar_step
`default_nettype wire

// >>> bcd_calendar_clock_alarm.sv
// bcd_calendar_clock_alarm: BCD calendar clock with alarm and register port.
// assumes a single clk domain and a master that strobes one cycle at a time.
// How it works
// - calendar 2000..2099 with automatic leap years
// - hours count 00..23 only
// - half-second bit read-only, cleared by seconds write
// - every time and alarm field held as BCD nibbles; the repeat counter counts in binary
// - time fields writable, counting resumes from them
// - run bit starts counting, an unlocked write of 0 stops it
// - seconds write clears the prescaler
// - written field updates in the write cycle
// - time writes need the unlock bit
// - run bit write ignored while locked
// - time writes allowed whether running or not
// - chime lets repeat counter wrap to FF
// - interval field selects alarm period
// - repeat counter decrements on each alarm above 00; at 00 without chime the alarm disarms instead
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none
module bcd_calendar_clock_alarm #(
	parameter int HALF_SEC_CYCLES = rtc_pkg::HALF_SEC_CYCLES_DEF
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic [rtc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	output logic                            seconds_pulse,
	output logic                            alarm_event
);
	import rtc_pkg::*;
	localparam int PW = $clog2(HALF_SEC_CYCLES + 1);
	localparam logic [PW-1:0] PRESC_LAST = PW'(HALF_SEC_CYCLES - 1);
	localparam logic [PW-1:0] SYNC_START = PW'(HALF_SEC_CYCLES - SYNC_WINDOW_CYCLES);

	time_s         now_r, now_nxt, stepped;
	alarm_s        alm_r, alm_nxt;
	logic [PW-1:0] presc_r, presc_nxt;
	logic          half_r, half_nxt;
	logic          run_r, run_nxt;
	logic          unlock_r, unlock_nxt;
	logic          arm_r, arm_nxt;
	logic          chime_r, chime_nxt;
	logic [3:0]    ivl_r, ivl_nxt;
	logic [7:0]    rpt_r, rpt_nxt;
	logic [7:0]    rdata_r, rdata_nxt;
	logic          sec_pulse_r, sec_pulse_nxt;
	logic          evt_r, evt_nxt;
	logic          tick;
	logic          sec_tick;
	logic          wr_time;
	logic          sync;

	calendar_step u_step (
		.cur (now_r),
		.nxt (stepped)
	);

	function automatic logic alarm_match(input logic [3:0] ivl, input time_s t,
		input alarm_s a);
		logic hms;
		hms = (t.hour == a.hour) && (t.min == a.min) && (t.sec == a.sec);
		case (ivl)
			IVL_SEC:  return 1'b1;
			IVL_10S:  return t.sec[3:0] == a.sec[3:0];
			IVL_MIN:  return t.sec == a.sec;
			IVL_10M:  return (t.min[3:0] == a.min[3:0]) && (t.sec == a.sec);
			IVL_HOUR: return (t.min == a.min) && (t.sec == a.sec);
			IVL_DAY:  return hms;
			IVL_WEEK: return hms && (t.wday == a.wday);
			IVL_MON:  return hms && (t.day == a.day);
			IVL_YEAR: return hms && (t.day == a.day) && (t.month == a.month);
			default:  return 1'b0; // reserved codes never fire
		endcase
	endfunction

	assign tick     = run_r && (presc_r == PRESC_LAST);
	assign sec_tick = tick && half_r;
	// run state is not consulted: writes go through stopped or running
	assign wr_time  = reg_wr && unlock_r && (reg_addr >= REG_YEAR) && (reg_addr <= REG_SECONDS);
	// warns software that a seconds increment is a few cycles away
	assign sync     = run_r && half_r && (presc_r >= SYNC_START);

	// time, prescaler and control bits
	always_comb begin
		now_nxt    = sec_tick ? stepped : now_r;
		presc_nxt  = presc_r;
		half_nxt   = half_r;
		run_nxt    = run_r;
		unlock_nxt = unlock_r;
		if (run_r) begin
			presc_nxt = tick ? '0 : PW'(presc_r + 1'b1);
			half_nxt  = tick ? ~half_r : half_r;
		end
		if (reg_wr && reg_addr == REG_CTRL) begin
			unlock_nxt = reg_wdata[CTRL_UNLOCK_BIT];
			if (unlock_r)
				run_nxt = reg_wdata[CTRL_RUN_BIT];
		end
		if (wr_time) begin
			// the written field lands this edge; the others keep counting
			if (reg_addr == REG_YEAR)
				now_nxt.year = reg_wdata;
			else if (reg_addr == REG_MONTH)
				now_nxt.month = reg_wdata;
			else if (reg_addr == REG_DAY)
				now_nxt.day = reg_wdata;
			else if (reg_addr == REG_WDAY)
				now_nxt.wday = reg_wdata;
			else if (reg_addr == REG_HOURS)
				now_nxt.hour = reg_wdata;
			else if (reg_addr == REG_MINUTES)
				now_nxt.min = reg_wdata;
			else if (reg_addr == REG_SECONDS) begin
				now_nxt.sec = reg_wdata;
				presc_nxt   = '0;
				half_nxt    = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			now_r    <= TIME_RST;
			presc_r  <= '0;
			half_r   <= 1'b0;
			run_r    <= 1'b0;
			unlock_r <= 1'b0;
		end else begin
			now_r    <= now_nxt;
			presc_r  <= presc_nxt;
			half_r   <= half_nxt;
			run_r    <= run_nxt;
			unlock_r <= unlock_nxt;
		end
	end

	// alarm: compared against the time as it will stand after this tick
	always_comb begin
		alm_nxt   = alm_r;
		arm_nxt   = arm_r;
		chime_nxt = chime_r;
		ivl_nxt   = ivl_r;
		rpt_nxt   = rpt_r;
		evt_nxt   = arm_r && ((ivl_r == IVL_HALF) ? tick
			: (sec_tick && alarm_match(ivl_r, stepped, alm_r)));
		if (evt_nxt) begin
			if (rpt_r != BCD_ZERO)
				rpt_nxt = 8'(rpt_r - 8'h01);
			else if (chime_r)
				rpt_nxt = RPT_MAX;
			else
				arm_nxt = 1'b0;
		end
		// a software write in the same cycle wins over the hardware update
		if (reg_wr && reg_addr == REG_ALARM_CTL) begin
			arm_nxt   = reg_wdata[AL_ARM_BIT];
			chime_nxt = reg_wdata[AL_CHIME_BIT];
			ivl_nxt   = reg_wdata[AL_IVL_LSB +: 4];
		end else if (reg_wr && reg_addr == REG_ALARM_RPT)
			rpt_nxt = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_MONTH)
			alm_nxt.month = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_DAY)
			alm_nxt.day = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_WDAY)
			alm_nxt.wday = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_HOURS)
			alm_nxt.hour = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_MIN)
			alm_nxt.min = reg_wdata;
		else if (reg_wr && reg_addr == REG_AL_SEC)
			alm_nxt.sec = reg_wdata;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alm_r   <= ALARM_RST;
			arm_r   <= 1'b0;
			chime_r <= 1'b0;
			ivl_r   <= IVL_HALF;
			rpt_r   <= BCD_ZERO;
			evt_r   <= 1'b0;
		end else begin
			alm_r   <= alm_nxt;
			arm_r   <= arm_nxt;
			chime_r <= chime_nxt;
			ivl_r   <= ivl_nxt;
			rpt_r   <= rpt_nxt;
			evt_r   <= evt_nxt;
		end
	end

	// read port: data valid only in the cycle after the strobe
	always_comb begin
		rdata_nxt     = 8'h00;
		sec_pulse_nxt = sec_tick;
		if (!reg_rd)
			rdata_nxt = 8'h00;
		else if (reg_addr == REG_CTRL) begin
			rdata_nxt[CTRL_RUN_BIT]    = run_r;
			rdata_nxt[CTRL_UNLOCK_BIT] = unlock_r;
			rdata_nxt[CTRL_SYNC_BIT]   = sync;
			rdata_nxt[CTRL_HALF_BIT]   = half_r;
		end else if (reg_addr == REG_ALARM_CTL) begin
			rdata_nxt[AL_ARM_BIT]         = arm_r;
			rdata_nxt[AL_CHIME_BIT]       = chime_r;
			rdata_nxt[AL_IVL_LSB +: 4]    = ivl_r;
		end else if (reg_addr == REG_ALARM_RPT)
			rdata_nxt = rpt_r;
		else if (reg_addr == REG_YEAR)
			rdata_nxt = now_r.year;
		else if (reg_addr == REG_MONTH)
			rdata_nxt = now_r.month;
		else if (reg_addr == REG_DAY)
			rdata_nxt = now_r.day;
		else if (reg_addr == REG_WDAY)
			rdata_nxt = now_r.wday;
		else if (reg_addr == REG_HOURS)
			rdata_nxt = now_r.hour;
		else if (reg_addr == REG_MINUTES)
			rdata_nxt = now_r.min;
		else if (reg_addr == REG_SECONDS)
			rdata_nxt = now_r.sec;
		else if (reg_addr == REG_AL_MONTH)
			rdata_nxt = alm_r.month;
		else if (reg_addr == REG_AL_DAY)
			rdata_nxt = alm_r.day;
		else if (reg_addr == REG_AL_WDAY)
			rdata_nxt = alm_r.wday;
		else if (reg_addr == REG_AL_HOURS)
			rdata_nxt = alm_r.hour;
		else if (reg_addr == REG_AL_MIN)
			rdata_nxt = alm_r.min;
		else
			rdata_nxt = alm_r.sec;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r     <= 8'h00;
			sec_pulse_r <= 1'b0;
		end else begin
			rdata_r     <= rdata_nxt;
			sec_pulse_r <= sec_pulse_nxt;
		end
	end

	assign reg_rdata     = rdata_r;
	assign seconds_pulse = sec_pulse_r;
	assign alarm_event   = evt_r;

	sequence seq_sec_write;
		reg_wr && reg_addr == REG_SECONDS && unlock_r;
	endsequence

	sequence seq_locked_write(logic [ADDR_W-1:0] a);
		reg_wr && reg_addr == a && !unlock_r;
	endsequence

	a_sec_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
		seq_sec_write |=> now_r.sec == $past(reg_wdata))
		else $error("seconds write did not land next edge");
	a_presc_half_clear: assert property (@(posedge clk) disable iff (sys_rst)
		seq_sec_write |=> presc_r == '0 && !half_r)
		else $error("seconds write left prescaler or half bit");
	a_locked_run_bit: assert property (@(posedge clk) disable iff (sys_rst)
		seq_locked_write(REG_CTRL) |=> run_r == $past(run_r))
		else $error("run bit changed while locked");
	a_locked_minutes: assert property (@(posedge clk) disable iff (sys_rst)
		seq_locked_write(REG_MINUTES) ##0 !sec_tick |=> $stable(now_r.min))
		else $error("minutes changed by a locked write");
	a_hour_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		sec_tick && !wr_time && now_r.hour == 8'h23 && now_r.min == 8'h59
		&& now_r.sec == 8'h59 |=> now_r.hour == 8'h00 && seconds_pulse)
		else $error("hour did not wrap to 00 after 23:59:59");
	a_leap_feb: assert property (@(posedge clk) disable iff (sys_rst)
		sec_tick && !wr_time && now_r.year == 8'h00 && now_r.month == 8'h02
		&& now_r.day == 8'h28 && stepped.hour == 8'h00 && now_r.hour == 8'h23
		|=> now_r.day == 8'h29)
		else $error("leap year february ended on the 28th");
	a_stopped_holds: assert property (@(posedge clk) disable iff (sys_rst)
		!run_r && !reg_wr [*2] |-> $stable(presc_r) && $stable(now_r))
		else $error("clock moved while stopped");
	a_arm_autoclear: assert property (@(posedge clk) disable iff (sys_rst)
		evt_nxt && rpt_r == 8'h00 && !chime_r && !reg_wr |=> !arm_r ##0 alarm_event)
		else $error("arm not cleared after final alarm");
	a_chime_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		evt_nxt && rpt_r == 8'h00 && chime_r && !reg_wr |=> rpt_r == 8'hFF && arm_r)
		else $error("chime did not wrap repeat counter");
	a_rpt_decrement: assert property (@(posedge clk) disable iff (sys_rst)
		evt_nxt && rpt_r != 8'h00 && !reg_wr |=> rpt_r == 8'($past(rpt_r) - 8'h01))
		else $error("repeat counter did not decrement");
	a_alarm_needs_arm: assert property (@(posedge clk) disable iff (sys_rst)
		alarm_event |-> $past(arm_r) && $past(tick))
		else $error("alarm fired unarmed or off a tick");
endmodule // bcd_calendar_clock_alarm
`default_nettype wire

// >>> bcd_calendar_clock_alarm_test.sv
// bcd_calendar_clock_alarm_test: self-checking bench for the BCD calendar clock.
// assumes the rtc package and design files are compiled first; half-second shortened to 40.
`default_nettype none
module bcd_calendar_clock_alarm_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_pkg::*;
	localparam int HS = 40;
	localparam time_s T0 = 56'h24_02_28_03_23_59_59;
	localparam logic [47:0] AL = 48'h02_29_04_00_00_00;
	localparam logic [55:0] CS [5] = '{56'h24_02_28_03_23_59_59, 56'h23_02_28_06_23_59_59,
		56'h00_02_28_01_23_59_59, 56'h98_12_31_02_23_59_59, 56'h24_04_30_02_09_59_59};
	localparam logic [55:0] CE [5] = '{56'h24_02_29_04_00_00_00, 56'h23_03_01_00_00_00_00,
		56'h00_02_29_02_00_00_00, 56'h99_01_01_03_00_00_00, 56'h24_04_30_02_10_00_00};
	logic              clk       = 1'b0;
	logic              sys_rst   = 1'b1;
	logic [ADDR_W-1:0] reg_addr  = 4'h0;
	logic [7:0]        reg_wdata = 8'h00;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [7:0]        reg_rdata;
	logic              seconds_pulse;
	logic              alarm_event;
	int                num_errors = 0;
	int                checks     = 0;
	int                n_alarm    = 0;

	bcd_calendar_clock_alarm #(.HALF_SEC_CYCLES(HS)) dut (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.seconds_pulse (seconds_pulse),
		.alarm_event   (alarm_event)
	);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (alarm_event === 1'b1) begin
			n_alarm <= n_alarm + 1;
		end
	end

	function automatic logic [7:0] bcd(input int x);
		return {4'(x / 10), 4'(x % 10)};
	endfunction

	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic note(input string what);
		$display("test %s done", what);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe edge
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rc(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, d, exp);
	endtask

	// bounded: returns 200 when no increment shows up
	task automatic wait_sec(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (seconds_pulse !== 1'b1 && n < 200);
	endtask

	// seconds first: clears the prescaler so no carry lands on the later writes
	task automatic set_time(input time_s t);
		wr(REG_SECONDS, t.sec);
		for (int i = 0; i < 6; i++) begin
			wr(4'(int'(REG_YEAR) + i), t[55-8*i -: 8]);
		end
	endtask

	task automatic cal(input time_s t, input time_s e);
		int n;
		logic [7:0] d;
		set_time(t);
		wait_sec(n);
		for (int i = 0; i < 7; i++) begin
			rd(4'(int'(REG_YEAR) + i), d);
			chk("calendar field", d, e[55-8*i -: 8]);
		end
		note("calendar step");
	endtask

	task automatic alarm_try(input logic [3:0] c, input logic [7:0] rpt, input logic chime,
			input int k, input int exp_n, input logic [7:0] exp_ctl, input logic [7:0] exp_rpt);
		int base;
		int n;
		set_time(T0);
		wr(REG_ALARM_RPT, rpt);
		wr(REG_ALARM_CTL, {1'b1, chime, c, 2'b00});
		base = n_alarm;
		repeat (k) wait_sec(n);
		repeat (3) @(posedge clk);
		chk("alarm count", 8'(n_alarm - base), 8'(exp_n));
		rc("alarm ctl", REG_ALARM_CTL, exp_ctl);
		rc("alarm rpt", REG_ALARM_RPT, exp_rpt);
		note("alarm");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		test_done();
	end

	initial begin
		int n;
		int s;
		logic [7:0] v;
		time_s t;
		time_s e;
		void'($urandom(73));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rc("ctrl reset", REG_CTRL, 8'h00);
		rc("month reset", REG_MONTH, 8'h01);
		wr(REG_YEAR, 8'h55);
		rc("locked year", REG_YEAR, 8'h00);
		wr(REG_MINUTES, 8'h12);
		rc("locked minutes", REG_MINUTES, 8'h00);
		wr(REG_CTRL, 8'h80);
		rc("locked run", REG_CTRL, 8'h00);
		wr(REG_CTRL, 8'h20);
		wr(REG_YEAR, 8'h55);
		rc("year write", REG_YEAR, 8'h55);
		wait_sec(n);
		chk("stopped", 8'(n), 8'hC8);
		set_time(T0);
		rc("seconds stopped", REG_SECONDS, 8'h59);
		note("lock");
		wr(REG_CTRL, 8'hA0);
		for (int i = 0; i < 5; i++) begin
			cal(CS[i], CE[i]);
		end
		for (int k = 0; k < 4; k++) begin
			s = $urandom % 59;
			t = {bcd($urandom % 100), bcd(1 + $urandom % 12), bcd(1 + $urandom % 28),
				bcd($urandom % 7), bcd($urandom % 24), bcd($urandom % 60), bcd(s)};
			e = t;
			e.sec = bcd(s + 1);
			cal(t, e);
		end
		wr(REG_CTRL, 8'h80);
		wr(REG_CTRL, 8'h00);
		rd(REG_CTRL, v);
		chk("run kept", v & 8'hA0, 8'h80);
		wait_sec(n);
		chk("running", 8'(n < 200), 8'h01);
		wr(REG_CTRL, 8'hA0);
		wr(REG_SECONDS, 8'h30);
		wait_sec(n);
		chk("prescaler", 8'(n >= 2 * HS - 2 && n <= 2 * HS + 2), 8'h01);
		repeat (HS + 5) @(posedge clk);
		rd(REG_CTRL, v);
		chk("half set", {7'h00, v[CTRL_HALF_BIT]}, 8'h01);
		// late in the second half: the warning window is open
		repeat (20) @(posedge clk);
		rd(REG_CTRL, v);
		chk("sync set", {7'h00, v[CTRL_SYNC_BIT]}, 8'h01);
		wr(REG_SECONDS, 8'h30);
		rd(REG_CTRL, v);
		chk("half clear", {7'h00, v[CTRL_HALF_BIT]}, 8'h00);
		chk("sync clear", {7'h00, v[CTRL_SYNC_BIT]}, 8'h00);
		note("timebase");
		for (int i = 0; i < 6; i++) begin
			wr(4'(int'(REG_AL_MONTH) + i), AL[47-8*i -: 8]);
			rc("alarm field", 4'(int'(REG_AL_MONTH) + i), AL[47-8*i -: 8]);
		end
		for (int c = 0; c < 16; c++) begin
			alarm_try(4'(c), 8'h00, 1'b0, 1, (c < 10) ? 1 : 0,
				{(c >= 10), 1'b0, 4'(c), 2'b00}, 8'h00);
		end
		alarm_try(IVL_HALF, 8'h02, 1'b0, 2, 3, 8'h00, 8'h00);
		alarm_try(IVL_HALF, 8'h00, 1'b1, 1, 2, 8'hC0, 8'hFE);
		wr(REG_AL_HOURS, 8'h01);
		alarm_try(IVL_DAY, 8'h00, 1'b0, 1, 0, 8'h98, 8'h00);
		alarm_try(IVL_MIN, 8'h00, 1'b0, 1, 1, 8'h0C, 8'h00);
		test_done();
	end
endmodule // bcd_calendar_clock_alarm_test
`default_nettype wire
